// [src/pmc_conv_setup.sv]
// SPI target with conversion setup, shunt scale and drift registers
// Notes on behaviour
// - Mode field 15-12, reset F; 0/8 shut down
// - Modes 1-7: one triggered pass, bits pick channels
// - Modes 9-F: continuous on selected channels
// - Bus conversion time field 11-9, reset 5
// - Shunt conversion time field 8-6, reset 5
// - Temperature conversion time field 5-3, reset 5
// - Averaging count field 2-0, reset 0
// - One averaging count for all channels
// - Results update only after full average
// - Shunt scale constant bits 14-0, reset 1000h
// - Shunt scale also sets current resolution
// - Reserved bits read back as zero
// - Drift coefficient bits 13-0, 1 ppm/C per step
// - Drift correction referenced to plus 25 C
// - Drift correction only while enable bit set
// - Frame: address, zero, read bit, 16 data
`timescale 1ns/100ps
module pmc_conv_setup #(
  parameter int TICK_DIV = pmc_pkg::PMC_CYC_PER_US
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      spi_sclk,
  input  wire logic                      spi_cs_n,
  input  wire logic                      spi_mosi,
  output logic                           spi_miso,
  output logic                           spi_miso_oe,
  output logic                           meas_busy,
  output logic [1:0]                     meas_chan,
  output logic                           result_update,
  output logic [1:0]                     result_chan,
  output pmc_pkg::pmc_setup_s            setup_word,
  output logic [pmc_pkg::PMC_SCALE_W-1:0] current_scale,
  output logic [pmc_pkg::PMC_COEFF_W-1:0] drift_coeff_eff
);

  typedef struct packed {
    logic [2:0]                     sclk_sy;
    logic [1:0]                     cs_sy;
    logic [1:0]                     mosi_sy;
    logic [4:0]                     bits;
    logic [15:0]                    shin;
    logic [5:0]                     addr;
    logic                           rd;
    logic                           bad;
    logic [15:0]                    shout;
    logic                           miso;
    logic                           oe;
    pmc_pkg::pmc_setup_s            setup;
    logic [pmc_pkg::PMC_SCALE_W-1:0] scale;
    logic [pmc_pkg::PMC_COEFF_W-1:0] coeff;
    logic                           drift_en;
    logic [pmc_pkg::PMC_COEFF_W-1:0] coeff_eff;
    logic                           start;
  } pmc_top_s;

  pmc_top_s s_q;
  pmc_top_s s_d;

  // Readback word; unmapped addresses and reserved bits give zero
  function automatic logic [15:0] rd_word(input pmc_top_s s,
                                          input logic [5:0] a);
    logic [15:0] w;
    w = 16'h0000;
    unique case (a)
      pmc_pkg::PMC_ADDR_MAIN_CFG: w[pmc_pkg::PMC_DRIFT_EN_BIT] = s.drift_en;
      pmc_pkg::PMC_ADDR_SETUP:    w = s.setup;
      pmc_pkg::PMC_ADDR_SCALE:    w = {1'b0, s.scale};
      pmc_pkg::PMC_ADDR_DRIFT:    w = {2'b00, s.coeff};
      default:                    w = 16'h0000;
    endcase
    return w;
  endfunction : rd_word

  // Frame engine, register writes and drift gating
  always_comb begin
    logic        rise;
    logic        fall;
    logic        cs_on;
    logic [15:0] word;
    s_d         = s_q;
    s_d.start   = 1'b0;
    s_d.sclk_sy = {s_q.sclk_sy[1:0], spi_sclk};
    s_d.cs_sy   = {s_q.cs_sy[0], spi_cs_n};
    s_d.mosi_sy = {s_q.mosi_sy[0], spi_mosi};
    rise  = s_q.sclk_sy[1] && !s_q.sclk_sy[2];
    fall  = !s_q.sclk_sy[1] && s_q.sclk_sy[2];
    cs_on = !s_q.cs_sy[1];
    word  = {s_q.shin[14:0], s_q.mosi_sy[1]};
    s_d.oe = cs_on;
    if (!cs_on) begin
      s_d.bits = 5'h00;
      s_d.miso = 1'b0;
    end else begin
      // Host drives on rising edge, device samples on falling
      if (rise) begin
        s_d.miso  = (s_q.bits >= pmc_pkg::PMC_CMD_BITS) && s_q.shout[15];
        if (s_q.bits >= pmc_pkg::PMC_CMD_BITS) begin
          s_d.shout = {s_q.shout[14:0], 1'b0};
        end
      end
      if (fall && s_q.bits < pmc_pkg::PMC_FRAME_BITS) begin
        s_d.shin = word;
        s_d.bits = s_q.bits + 5'h01;
        if (s_q.bits == pmc_pkg::PMC_CMD_BITS - 5'h01) begin
          s_d.addr  = word[7:2];
          s_d.bad   = word[1];
          s_d.rd    = word[0];
          s_d.shout = rd_word(s_q, word[7:2]);
        end
        // write commits on last data bit
        if (s_q.bits == pmc_pkg::PMC_FRAME_BITS - 5'h01
            && !s_q.rd && !s_q.bad) begin
          unique case (s_q.addr)
            pmc_pkg::PMC_ADDR_MAIN_CFG:
              s_d.drift_en = word[pmc_pkg::PMC_DRIFT_EN_BIT];
            pmc_pkg::PMC_ADDR_SETUP: begin
              s_d.setup = word;
              s_d.start = 1'b1;
            end
            pmc_pkg::PMC_ADDR_SCALE: s_d.scale = word[14:0];
            pmc_pkg::PMC_ADDR_DRIFT: s_d.coeff = word[13:0];
            default: s_d.start = 1'b0;
          endcase
        end
      end
    end
    s_d.coeff_eff = s_q.drift_en ? s_q.coeff : '0;
  end

  // Register the state; setup fields take their documented resets
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q         <= '0;
      s_q.setup   <= pmc_pkg::PMC_SETUP_RST;
      s_q.scale   <= pmc_pkg::PMC_SCALE_RST;
      s_q.coeff   <= pmc_pkg::PMC_COEFF_RST;
      s_q.sclk_sy <= 3'b000;
      s_q.cs_sy   <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end

  pmc_sequencer #(
    .TICK_DIV (TICK_DIV)
  ) u_seq (
    .core_clk      (core_clk),
    .rst           (rst),
    .setup         (s_q.setup),
    .start         (s_q.start),
    .busy          (meas_busy),
    .chan          (meas_chan),
    .result_update (result_update),
    .result_chan   (result_chan)
  );

  assign spi_miso        = s_q.miso;
  assign spi_miso_oe     = s_q.oe;
  assign setup_word      = s_q.setup;
  assign current_scale   = s_q.scale;
  assign drift_coeff_eff = s_q.coeff_eff;

  a_reset_setup: assert property (
    @(posedge core_clk)
    rst |=> setup_word == pmc_pkg::PMC_SETUP_RST
            && current_scale == pmc_pkg::PMC_SCALE_RST
            && drift_coeff_eff == '0)
    else $error("Bad reset values");
  a_setup_start: assert property (
    @(posedge core_clk) disable iff (rst)
    $changed(setup_word) |-> s_q.start)
    else $error("No start on write");
  a_drift_gate: assert property (
    @(posedge core_clk) disable iff (rst)
    !s_q.drift_en [*2] |-> drift_coeff_eff == '0)
    else $error("Correction while disabled");
  a_scale_rsvd: assert property (
    @(posedge core_clk) disable iff (rst)
    (s_q.bits == pmc_pkg::PMC_CMD_BITS && $changed(s_q.bits)
     && s_q.addr == pmc_pkg::PMC_ADDR_SCALE) |-> !s_q.shout[15])
    else $error("Reserved bit read as one");
  // Only the next cycle: a new frame may already select the pin after it
  a_miso_off: assert property (
    @(posedge core_clk) disable iff (rst)
    s_q.cs_sy[1] |=> !spi_miso_oe && !spi_miso)
    else $error("Output driven outside frame");

endmodule : pmc_conv_setup

// [src/pmc_pkg.sv]
// Shared constants and types of the conversion setup block
package pmc_pkg;

  // Register addresses carried in the command byte
  localparam logic [5:0] PMC_ADDR_MAIN_CFG = 6'h00;
  localparam logic [5:0] PMC_ADDR_SETUP    = 6'h01;
  localparam logic [5:0] PMC_ADDR_SCALE    = 6'h02;
  localparam logic [5:0] PMC_ADDR_DRIFT    = 6'h03;

  // Values after reset
  localparam logic [15:0] PMC_SETUP_RST = 16'hFB68;
  localparam logic [14:0] PMC_SCALE_RST = 15'h1000;
  localparam logic [13:0] PMC_COEFF_RST = 14'h0000;

  // Field positions
  localparam int PMC_DRIFT_EN_BIT = 5;
  localparam int PMC_SCALE_W      = 15;
  localparam int PMC_COEFF_W      = 14;

  // Frame layout: command byte then one 16-bit data word
  localparam logic [4:0] PMC_CMD_BITS   = 5'h08;
  localparam logic [4:0] PMC_FRAME_BITS = 5'h18;

  // Reference die temperature of drift correction, degrees C
  localparam logic [7:0] PMC_DRIFT_REF_C = 8'h19;

  // Timing: one time base tick per microsecond
  localparam int PMC_CLK_NS     = 25;
  localparam int PMC_TICK_NS    = 1000;
  localparam int PMC_CYC_PER_US = PMC_TICK_NS / PMC_CLK_NS;

  // Conversion times in microseconds, code 7 down to code 0
  localparam logic [7:0][12:0] PMC_CONV_US = {
    13'd4120, 13'd2074, 13'd1052, 13'd540,
    13'd280,  13'd150,  13'd84,   13'd50};

  // Samples per averaged result, code 7 down to code 0
  localparam logic [7:0][10:0] PMC_AVG_N = {
    11'd1024, 11'd512, 11'd256, 11'd128,
    11'd64,   11'd16,  11'd4,   11'd1};

  // Conversion setup word as stored
  typedef struct packed {
    logic [3:0] mode;
    logic [2:0] bus_conv_time;
    logic [2:0] shunt_conv_time;
    logic [2:0] temp_conv_time;
    logic [2:0] sample_average_count;
  } pmc_setup_s;

  // Sequencer states, Gray along idle -> convert -> idle
  typedef enum logic [1:0] {
    PMC_SQ_IDLE = 2'b00,
    PMC_SQ_CONV = 2'b01
  } pmc_sq_e;

endpackage : pmc_pkg

// [src/pmc_sequencer.sv]
// Measurement pass sequencer driven by the conversion setup word
`timescale 1ns/100ps
module pmc_sequencer #(
  parameter int TICK_DIV = pmc_pkg::PMC_CYC_PER_US
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire pmc_pkg::pmc_setup_s setup,
  input  wire logic               start,
  output logic                    busy,
  output logic [1:0]              chan,
  output logic                    result_update,
  output logic [1:0]              result_chan
);

  typedef struct packed {
    pmc_pkg::pmc_sq_e st;
    logic             pend;
    logic [1:0]       chan;
    logic [15:0]      div;
    logic [12:0]      us;
    logic [10:0]      samp;
    logic             upd;
    logic [1:0]       upd_chan;
  } pmc_seq_s;

  pmc_seq_s s_q;
  pmc_seq_s s_d;

  // Lowest enabled channel above cur (or from 0 when first)
  function automatic logic [2:0] next_ch(input logic [2:0] en,
                                         input logic [1:0] cur,
                                         input logic       first);
    logic [2:0] r;
    r = 3'b000;
    for (int i = 2; i >= 0; i--) begin
      if (en[i] && (first || i > int'(cur))) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction : next_ch

  // Conversion time of a channel in microseconds
  function automatic logic [12:0] conv_us(input pmc_pkg::pmc_setup_s c,
                                          input logic [1:0]          ch);
    logic [2:0] code;
    code = (ch == 2'd0) ? c.bus_conv_time :
           (ch == 2'd1) ? c.shunt_conv_time : c.temp_conv_time;
    return pmc_pkg::PMC_CONV_US[code];
  endfunction : conv_us

  logic [2:0]  en;
  logic        cont;
  logic        trig;
  logic [10:0] avg_n;
  assign en    = setup.mode[2:0];
  assign cont  = setup.mode[3] && (en != 3'b000);
  assign trig  = !setup.mode[3] && (en != 3'b000);
  // One count for every enabled channel
  // shared averaging count
  assign avg_n = pmc_pkg::PMC_AVG_N[setup.sample_average_count];

  // Next state of the whole sequencer
  always_comb begin
    logic [2:0] nx;
    logic       tick;
    s_d     = s_q;
    s_d.upd = 1'b0;
    nx      = 3'b000;
    tick    = (s_q.div == 16'(TICK_DIV - 1));
    unique case (s_q.st)
      pmc_pkg::PMC_SQ_IDLE: begin
        nx = next_ch(en, 2'd0, 1'b1);
        if ((cont || (trig && s_q.pend)) && nx[2]) begin
          s_d.st   = pmc_pkg::PMC_SQ_CONV;
          s_d.pend = 1'b0;
          s_d.chan = nx[1:0];
          s_d.us   = conv_us(setup, nx[1:0]);
          s_d.samp = 11'h000;
          s_d.div  = 16'h0000;
        end else if (!trig) begin
          s_d.pend = 1'b0;
        end
      end
      pmc_pkg::PMC_SQ_CONV: begin
        s_d.div = tick ? 16'h0000 : s_q.div + 16'h0001;
        if (tick) begin
          s_d.us = s_q.us - 13'h0001;
        end
        if (tick && s_q.us == 13'h0001) begin
          if (s_q.samp == avg_n - 11'h001) begin
            s_d.upd      = 1'b1;
            s_d.upd_chan = s_q.chan;
            s_d.samp     = 11'h000;
            nx           = next_ch(en, s_q.chan, 1'b0);
            if (nx[2]) begin
              s_d.chan = nx[1:0];
              s_d.us   = conv_us(setup, nx[1:0]);
            end else begin
              s_d.st = pmc_pkg::PMC_SQ_IDLE;
            end
          end else begin
            s_d.samp = s_q.samp + 11'h001;
            s_d.us   = conv_us(setup, s_q.chan);
          end
        end
      end
      default: s_d.st = pmc_pkg::PMC_SQ_IDLE;
    endcase
    if (start) begin
      s_d.st   = pmc_pkg::PMC_SQ_IDLE;
      s_d.pend = 1'b1;
      s_d.upd  = 1'b0;
    end
  end

  // Register the state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy          = (s_q.st == pmc_pkg::PMC_SQ_CONV);
  assign chan          = s_q.chan;
  assign result_update = s_q.upd;
  assign result_chan   = s_q.upd_chan;

  a_shutdown_stays: assert property (
    @(posedge core_clk) disable iff (rst)
    (en == 3'b000 && !busy) |=> !busy)
    else $error("Shutdown converted");
  a_trig_single: assert property (
    @(posedge core_clk) disable iff (rst)
    (trig && !busy && !s_q.pend && !start) |=> !busy)
    else $error("Extra triggered pass");
  a_cont_loops: assert property (
    @(posedge core_clk) disable iff (rst)
    (cont && !busy && !start) |=> busy)
    else $error("Continuous did not restart");
  a_chan_selected: assert property (
    @(posedge core_clk) disable iff (rst)
    (busy && !start) |-> en[chan])
    else $error("Disabled channel");
  a_avg_complete: assert property (
    @(posedge core_clk) disable iff (rst)
    (busy && !start && s_q.us == 13'h0001
     && s_q.div == 16'(TICK_DIV - 1) && s_q.samp == avg_n - 11'h001)
    |=> result_update && result_chan == $past(chan))
    else $error("Averaged result not posted");
  // Count taken from the cycle that set the pulse, not a new setup
  a_no_early_upd: assert property (
    @(posedge core_clk) disable iff (rst)
    result_update |-> $past(s_q.samp) == $past(avg_n) - 11'h001)
    else $error("Result posted mid average");

endmodule : pmc_sequencer

// [verification/pmc_spi_host.sv]
// SPI controller model that stands at the host side of the setup block
`timescale 1ns/100ps
module pmc_spi_host (
  input  wire logic core_clk,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe
);
  int   half = 5;  // Core cycles per half sclk; below 3 the host samples miso before the target updates it
  logic oe_mid;

  // Idle bus: clock low, nothing selected
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  task automatic xfer(input logic [5:0] a, input logic rd, input logic z,
                      input logic [15:0] d, output logic [15:0] q);
    logic [23:0] f;
    f = {a, z, rd, d};
    q = 16'h0000;
    @(negedge core_clk);
    spi_cs_n = 1'b0;
    repeat (half) @(negedge core_clk);
    // Data moves on the rise, both ends sample on the fall
    for (int i = 23; i >= 0; i--) begin
      spi_sclk = 1'b1;
      spi_mosi = f[i];
      repeat (half) @(negedge core_clk);
      spi_sclk = 1'b0;
      if (i < 16) q = {q[14:0], spi_miso};
      if (i == 12) oe_mid = spi_miso_oe;
      repeat (half) @(negedge core_clk);
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;  // Released line must not keep its last bit
    repeat (6) @(negedge core_clk);
  endtask : xfer
endmodule : pmc_spi_host

// [verification/test_pmc_conv_setup.sv]
// Self-checking bench of the conversion setup block
`timescale 1ns/100ps
module test_pmc_conv_setup;
  localparam int TICK = 1;  // One cycle per us keeps passes short
  localparam int CT[8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  logic                core_clk = 1'b0;
  logic                rst = 1'b1;
  logic                spi_sclk, spi_cs_n, spi_mosi, spi_miso;
  logic                spi_miso_oe, meas_busy, result_update;
  logic [1:0]          meas_chan, result_chan;
  pmc_pkg::pmc_setup_s setup_word;
  logic [14:0]         current_scale;
  logic [13:0]         drift_coeff_eff;
  logic [15:0]         rd, wv;
  logic [15:0]         shadow [4];
  logic [3:0]          m;
  logic [2:0]          seen, c, bseen;
  int                  bad_count, comparisons, cnt, e, a;
  int                  tq [4];

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  pmc_conv_setup #(.TICK_DIV(TICK)) dut_u (
    .core_clk(core_clk), .rst(rst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .meas_busy(meas_busy),
    .meas_chan(meas_chan), .result_update(result_update),
    .result_chan(result_chan), .setup_word(setup_word),
    .current_scale(current_scale), .drift_coeff_eff(drift_coeff_eff));

  pmc_spi_host host_u (
    .core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

  // Compare one value, count it, report a difference
  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Closing report and verdict
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // Writable bits of each register; reserved ones read zero
  function automatic logic [15:0] rmask(input int r);
    return (r == 0) ? 16'h0020 : (r == 2) ? 16'h7FFF :
           (r == 3) ? 16'h3FFF : 16'hFFFF;
  endfunction : rmask

  // Loose window: a cycle or two per channel hand-over is allowed
  function automatic logic [31:0] near(input int t, input int x);
    return (t >= x - 1 && t <= x + 6) ? 32'h0000_0001 : 32'h0000_0000;
  endfunction : near

  // Counts result pulses over a window, times from busy rise
  task automatic watch(input int win, input logic from_busy);
    int t;
    t = 0;
    cnt = 0;
    seen = 3'h0;
    bseen = 3'h0;
    while (from_busy && meas_busy !== 1'b1 && t < 600) begin
      @(negedge core_clk);
      t++;
    end
    if (t >= 600) begin
      check("busy_rise", 0, 1);
      tally_and_finish();
    end
    for (t = 1; t <= win; t++) begin
      @(negedge core_clk);
      if (meas_busy === 1'b1) bseen[meas_chan] = 1'b1;
      if (result_update === 1'b1) begin
        if (cnt < 4) tq[cnt] = t;
        cnt++;
        seen[result_chan] = 1'b1;
      end
    end
  endtask : watch

  // Main sequence
  initial begin
    void'($urandom(32'hebd2_c027));
    shadow = '{16'h0000, 16'hFB68, 16'h1000, 16'h0000};
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    check("setup_rst", setup_word, 16'hFB68);
    check("scale_rst", current_scale, 16'h1000);
    check("drift_rst", drift_coeff_eff, 0);
    repeat (4) @(negedge core_clk);
    check("busy_rst", meas_busy, 1);
    for (int r = 0; r < 4; r++) begin
      host_u.xfer(r[5:0], 1'b1, 1'b0, 16'h0000, rd);
      check("reset_read", rd, shadow[r]);
    end
    // writes, old word out, read back
    for (int i = 0; i < 14; i++) begin
      a = (i < 4) ? 3 - i : int'($urandom_range(3, 0));
      wv = (i < 4) ? 16'hFFFF : 16'($urandom);
      host_u.half = (i % 2 == 1) ? 8 : 5;
      host_u.xfer(a[5:0], 1'b0, 1'b0, wv, rd);
      check("old_word", rd, shadow[a]);
      shadow[a] = wv & rmask(a);
      host_u.xfer(a[5:0], 1'b1, 1'b0, 16'h0000, rd);
      check("read_back", rd, shadow[a]);
      check("oe_frame", host_u.oe_mid, 1);
      check("setup_out", setup_word, shadow[1]);
      check("scale_out", current_scale, shadow[2]);
      check("drift_out", drift_coeff_eff,
            shadow[0][5] ? shadow[3] : 16'h0000);
    end
    host_u.half = 5;
    host_u.xfer(6'h02, 1'b0, 1'b1, ~shadow[2], rd);
    host_u.xfer(6'h2A, 1'b0, 1'b0, 16'hFFFF, rd);
    host_u.xfer(6'h02, 1'b1, 1'b0, 16'h0000, rd);
    check("refused", rd, shadow[2]);
    host_u.xfer(6'h2A, 1'b1, 1'b0, 16'h0000, rd);
    check("unmapped", rd, 0);
    // every conversion time code per channel
    for (int k = 0; k < 24; k++) begin
      m = 4'h1 << (k / 8);
      c = 3'(k);
      e = CT[c] * TICK;
      host_u.xfer(6'h01, 1'b0, 1'b0, 16'h0000, rd);
      fork
        host_u.xfer(6'h01, 1'b0, 1'b0, {m, c, c, c, 3'h0}, rd);
        watch(e + 20, 1'b1);
      join
      check("conv_time", near(tq[0], e), 1);
      check("conv_chan", seen, m[2:0]);
      check("busy_chan", bseen, m[2:0]);
    end
    // one averaging count on all channels
    for (int k = 0; k < 4; k++) begin
      e = (4 ** k) * 50 * TICK;
      host_u.xfer(6'h01, 1'b0, 1'b0, 16'h0000, rd);
      fork
        host_u.xfer(6'h01, 1'b0, 1'b0, {4'h7, 9'h000, 3'(k)}, rd);
        watch(3 * e + 20, 1'b1);
      join
      check("avg_count", cnt, 3);
      check("avg_chans", bseen, 3'h7);
      for (int j = 0; j < 3; j++) begin
        check("avg_time", near(tq[j], (j + 1) * e), 1);
      end
    end
    // averaging code 4 on the bus channel alone
    e = 128 * 50 * TICK;
    host_u.xfer(6'h01, 1'b0, 1'b0, 16'h0000, rd);
    fork
      host_u.xfer(6'h01, 1'b0, 1'b0, {4'h1, 9'h000, 3'h4}, rd);
      watch(e + 20, 1'b1);
    join
    check("avg_128", near(tq[0], e), 1);
    check("avg_128_cnt", cnt, 1);
    for (int k = 0; k < 16; k++) begin
      m = 4'(k);
      host_u.xfer(6'h01, 1'b0, 1'b0, {m, 12'h000}, rd);
      watch(600, 1'b0);
      check("mode_chan", seen, m[2:0]);
      if (m[3] == 1'b0 || m[2:0] == 3'h0) begin
        check("mode_cnt", cnt, $countones(m[2:0]));
        check("mode_idle", meas_busy, 0);
      end else begin
        check("mode_cont", cnt > 2 * $countones(m[2:0]), 1);
      end
    end
    tally_and_finish();
  end
endmodule : test_pmc_conv_setup
